// ==== logic/prf_panel.sv ====
// Purpose: Panel button, auto restart, filter service and one-touch control
// Assumes: APB slave, zero wait states; nonvolatile store kept outside
// Notes: Power return is the release of presetn
`timescale 1ns/1ps
`include "prf_regs.svh"
module prf_panel import prf_pkg::*; #(
    parameter int unsigned CYC_PER_TICK = `PRF_CYC_PER_TICK,
    parameter int unsigned FILTER_TICKS = `PRF_FILTER_T,
    parameter int unsigned RESUME_TICKS = `PRF_RESUME_T,
    parameter logic [5:0] AUTO_COOL_C = 6'd25,
    parameter logic [5:0] AUTO_HEAT_C = 6'd21
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic btn_n,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_code,
    input wire logic [2:0] cmd_mode,
    input wire logic [4:0] cmd_temp,
    input wire logic [5:0] room_temp,
    input wire logic nvm_restart_en,
    input wire logic nvm_run,
    input wire logic [2:0] nvm_mode,
    input wire logic [4:0] nvm_temp,
    output logic nvm_wr,
    output logic run,
    output logic comfort,
    output logic restart_en,
    output logic [2:0] op_mode,
    output logic [4:0] target_temp,
    output logic fan_auto,
    output logic [3:0] louver,
    output logic white_led,
    output logic filter_led,
    output logic beep,
    output logic irq
);
    localparam logic [6:0] HOLD_MIN = 7'(`PRF_HOLD_MIN_T);
    localparam logic [6:0] HOLD_MAX = 7'(`PRF_HOLD_MAX_T);
    localparam logic [6:0] ACK_WAIT = 7'(`PRF_ACK_WAIT_T);
    localparam logic [6:0] FLASH_T = 7'(`PRF_FLASH_T);
    localparam logic [6:0] BEEP_T = 7'(2 * `PRF_BEEPS);

    // Mode the unit may really run, given system type
    function automatic prf_mode_t pick(input prf_mode_t m, input logic [5:0] t,
                                       input prf_sys_t s);
        prf_mode_t r;
        r = m;
        if (m == PRF_M_AUTO) begin
            if (t >= AUTO_COOL_C && s != PRF_SYS_HEAT) begin
                r = PRF_M_COOL;
            end else if (t <= AUTO_HEAT_C && s != PRF_SYS_COOL) begin
                r = PRF_M_HEAT;
            end else begin
                r = PRF_M_FAN;
            end
        end else if (m == PRF_M_HEAT && s == PRF_SYS_COOL) begin
            r = PRF_M_FAN;
        end else if ((m == PRF_M_COOL || m == PRF_M_DRY) && s == PRF_SYS_HEAT) begin
            r = PRF_M_FAN;
        end
        return r;
    endfunction

    logic [31:0] div_q;
    logic tick_q;
    logic b1_q, b2_q, b3_q, pressed_q;
    logic [6:0] hold_q;
    logic [25:0] hrs_q;
    logic filter_q, run_q, comfort_q, restart_q, fan_auto_q, loaded_q, pend_q;
    logic [10:0] res_cnt_q;
    prf_mode_t set_mode_q, op_mode_q;
    logic [4:0] temp_q;
    logic [3:0] louver_q;
    prf_ack_t ack_q;
    logic [6:0] ack_cnt_q;
    logic white_q, beep_q, nvm_wr_q, irq_q;
    logic [12:0] snap_q;
    prf_sys_t sys_q;
    logic [3:0] stat_q, mask_q;
    logic [15:0] louv_tab_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    logic rel, short_rel, qual_rel, resume_now, cmd_go, apb_wr;
    logic [3:0] ev;

    assign rel = pressed_q && (b2_q == b3_q) && !b2_q;
    assign short_rel = rel && hold_q < HOLD_MIN;
    assign qual_rel = rel && hold_q > HOLD_MIN && hold_q < HOLD_MAX;
    assign cmd_go = cmd_valid && cmd_code != PRF_CMD_NONE;
    assign resume_now = pend_q && tick_q && res_cnt_q == 11'(RESUME_TICKS - 1);
    assign apb_wr = psel && penable && pwrite && pready_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 32'h0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (div_q == CYC_PER_TICK - 1);
            div_q <= (div_q == CYC_PER_TICK - 1) ? 32'h0 : div_q + 32'h1;
        end
    end

    // Pin passes three stages; level taken once last two agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            b1_q <= 1'b0;
            b2_q <= 1'b0;
            b3_q <= 1'b0;
            pressed_q <= 1'b0;
        end else begin
            b1_q <= ~btn_n;
            b2_q <= b1_q;
            b3_q <= b2_q;
            if (b2_q == b3_q) begin
                pressed_q <= b2_q;
            end
        end
    end

    // Saturates past the long limit so a very long hold is ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q <= 7'h0;
        end else if (!pressed_q) begin
            hold_q <= 7'h0;
        end else if (tick_q && hold_q <= HOLD_MAX) begin
            hold_q <= hold_q + 7'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hrs_q <= 26'h0;
            filter_q <= 1'b0;
        end else if (short_rel && filter_q) begin
            hrs_q <= 26'h0;
            filter_q <= 1'b0;
        end else if (run_q && tick_q && !filter_q) begin
            hrs_q <= hrs_q + 26'h1;
            if (hrs_q == 26'(FILTER_TICKS - 1)) begin
                filter_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restart_q <= 1'b0;
            loaded_q <= 1'b0;
        end else if (!loaded_q) begin
            loaded_q <= 1'b1;
            restart_q <= nvm_restart_en;
        // Same hold turns it back off
        end else if (qual_rel) begin
            restart_q <= ~restart_q;
        end
    end

    // Any user action cancels a pending resume
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= 1'b0;
            res_cnt_q <= 11'h0;
        end else if (!loaded_q) begin
            pend_q <= nvm_restart_en && nvm_run;
        end else if (cmd_go || rel || resume_now) begin
            pend_q <= 1'b0;
        end else if (pend_q && tick_q) begin
            res_cnt_q <= res_cnt_q + 11'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 1'b0;
            comfort_q <= 1'b0;
            set_mode_q <= PRF_M_AUTO;
            temp_q <= `PRF_COMFORT_C;
            fan_auto_q <= 1'b1;
        end else if (!loaded_q) begin
            set_mode_q <= prf_mode_t'(nvm_mode);
            temp_q <= nvm_temp;
        end else if (cmd_go) begin
            case (prf_cmd_t'(cmd_code))
                PRF_CMD_ON: begin
                    run_q <= 1'b1;
                end
                PRF_CMD_OFF: begin
                    run_q <= 1'b0;
                    comfort_q <= 1'b0;
                end
                PRF_CMD_ONE_TOUCH: begin
                    run_q <= 1'b1;
                    comfort_q <= 1'b1;
                    set_mode_q <= PRF_M_AUTO;
                    temp_q <= `PRF_COMFORT_C;
                    fan_auto_q <= 1'b1;
                end
                default: begin
                    comfort_q <= 1'b0;
                    set_mode_q <= prf_mode_t'(cmd_mode);
                    temp_q <= cmd_temp;
                end
            endcase
        end else if ((short_rel && !filter_q) || qual_rel) begin
            run_q <= ~run_q;
            comfort_q <= 1'b0;
            if (!run_q) begin
                set_mode_q <= PRF_M_AUTO;
                temp_q <= `PRF_COMFORT_C;
                fan_auto_q <= 1'b1;
            end
        end else if (resume_now) begin
            run_q <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_mode_q <= PRF_M_FAN;
            louver_q <= 4'h0;
        end else begin
            op_mode_q <= pick(set_mode_q, room_temp, sys_q);
            if (comfort_q && op_mode_q != PRF_M_AUTO) begin
                louver_q <= louv_tab_q[4 * (op_mode_q - 3'h1) +: 4];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_q <= PRF_ACK_IDLE;
            ack_cnt_q <= 7'h0;
        end else if (qual_rel) begin
            ack_q <= PRF_ACK_WAIT;
            ack_cnt_q <= 7'h0;
        end else if (tick_q) begin
            ack_cnt_q <= ack_cnt_q + 7'h1;
            case (ack_q)
                PRF_ACK_WAIT: begin
                    if (ack_cnt_q == ACK_WAIT - 7'h1) begin
                        ack_q <= PRF_ACK_BEEP;
                        ack_cnt_q <= 7'h0;
                    end
                end
                PRF_ACK_BEEP: begin
                    if (ack_cnt_q == BEEP_T - 7'h1) begin
                        ack_q <= PRF_ACK_FLASH;
                        ack_cnt_q <= 7'h0;
                    end
                end
                PRF_ACK_FLASH: begin
                    if (ack_cnt_q == FLASH_T - 7'h1) begin
                        ack_q <= PRF_ACK_IDLE;
                    end
                end
                default: begin
                    ack_cnt_q <= 7'h0;
                end
            endcase
        end
    end

    // Beep on even ticks, lamp flashes after beeps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            beep_q <= 1'b0;
            white_q <= 1'b0;
        end else begin
            beep_q <= (ack_q == PRF_ACK_BEEP) && !ack_cnt_q[0];
            white_q <= (ack_q == PRF_ACK_FLASH) ? !ack_cnt_q[0] : run_q;
        end
    end

    // Store strobe on any change to kept settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            snap_q <= 13'h0;
            nvm_wr_q <= 1'b0;
        end else begin
            snap_q <= {restart_q, run_q, comfort_q, fan_auto_q, set_mode_q, temp_q, loaded_q};
            nvm_wr_q <= loaded_q && snap_q[0] &&
                        snap_q != {restart_q, run_q, comfort_q, fan_auto_q, set_mode_q,
                                   temp_q, loaded_q};
        end
    end

    assign ev[`PRF_EV_FILTER] = run_q && tick_q && !filter_q && hrs_q == 26'(FILTER_TICKS - 1);
    assign ev[`PRF_EV_TOGGLE] = qual_rel;
    assign ev[`PRF_EV_RESUME] = resume_now && !cmd_go && !rel;
    assign ev[`PRF_EV_COMFORT] = cmd_go && cmd_code == PRF_CMD_ONE_TOUCH;

    // Set beats a same-cycle write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= 4'h0;
            irq_q <= 1'b0;
        end else begin
            if (apb_wr && paddr == `PRF_IRQ_STAT) begin
                stat_q <= (stat_q & ~pwdata[3:0]) | ev;
            end else begin
                stat_q <= stat_q | ev;
            end
            irq_q <= |(stat_q & mask_q);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_q <= prf_sys_t'(`PRF_CFG_RST);
            mask_q <= `PRF_MASK_RST;
            louv_tab_q <= `PRF_LOUVER_RST;
        end else if (apb_wr) begin
            if (paddr == `PRF_CFG) begin
                sys_q <= prf_sys_t'(pwdata[1:0]);
            end else if (paddr == `PRF_IRQ_MASK) begin
                mask_q <= pwdata[3:0];
            end else if (paddr == `PRF_LOUVER) begin
                louv_tab_q <= pwdata[15:0];
            end
        end
    end

    // Read data latched in setup so access phase needs no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
            pready_q <= 1'b0;
        end else begin
            pready_q <= 1'b1;
            if (psel && !penable) begin
                pslverr_q <= 1'b0;
                prdata_q <= 32'h0;
                if (paddr == `PRF_CFG) begin
                    prdata_q <= {30'h0, sys_q};
                end else if (paddr == `PRF_STATUS) begin
                    prdata_q <= {25'h0, op_mode_q, filter_q, restart_q, comfort_q, run_q};
                end else if (paddr == `PRF_HOURS) begin
                    prdata_q <= {6'h0, hrs_q};
                end else if (paddr == `PRF_IRQ_STAT) begin
                    prdata_q <= {28'h0, stat_q};
                end else if (paddr == `PRF_IRQ_MASK) begin
                    prdata_q <= {28'h0, mask_q};
                end else if (paddr == `PRF_LOUVER) begin
                    prdata_q <= {16'h0, louv_tab_q};
                end else begin
                    pslverr_q <= 1'b1;
                end
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign nvm_wr = nvm_wr_q;
    assign run = run_q;
    assign comfort = comfort_q;
    assign restart_en = restart_q;
    assign op_mode = op_mode_q;
    assign target_temp = temp_q;
    assign fan_auto = fan_auto_q;
    assign louver = louver_q;
    assign white_led = white_q;
    assign filter_led = filter_q;
    assign beep = beep_q;
    assign irq = irq_q;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_qual;
        qual_rel && !cmd_go;
    endsequence
    sequence s_wait_done;
        ack_q == PRF_ACK_WAIT && tick_q && ack_cnt_q == ACK_WAIT - 7'h1;
    endsequence

    a_filter_lights: assert property (ev[`PRF_EV_FILTER] |=> filter_q)
        else $error("filter lamp missed threshold");
    a_filter_reset: assert property (short_rel && filter_q |=> !filter_q && hrs_q == 26'h0)
        else $error("filter reset failed");
    a_short_start: assert property (short_rel && !filter_q && !run_q && !cmd_go |=> run_q)
        else $error("short press did not start");
    a_resume_run: assert property (resume_now && !cmd_go && !rel |=> run_q)
        else $error("resume did not run");
    a_ship_off: assert property (!loaded_q |-> !restart_q)
        else $error("restart enabled before load");
    a_hold_window: assert property (rel && !qual_rel |=> $stable(restart_q))
        else $error("restart toggled outside window");
    a_ack_steps: assert property (s_qual |=> ack_q == PRF_ACK_WAIT ##0 !beep_q)
        else $error("ack did not wait first");
    a_beep_phase: assert property (s_wait_done |=> ack_q == PRF_ACK_BEEP ##2 beep_q)
        else $error("no beep after wait");
    a_hold_stops: assert property (s_qual and run_q |=> !run_q ##2 !white_led)
        else $error("hold did not stop");
    a_no_resume: assert property ($rose(loaded_q) && !$past(nvm_restart_en) |-> !pend_q)
        else $error("resume pending while disabled");
    a_one_touch: assert property (ev[`PRF_EV_COMFORT] |=> run_q && comfort_q && fan_auto_q
        && temp_q == `PRF_COMFORT_C && set_mode_q == PRF_M_AUTO)
        else $error("one touch settings wrong");
    a_comfort_exit: assert property (comfort_q && cmd_valid && cmd_code == PRF_CMD_MODE
        |=> !comfort_q)
        else $error("comfort not cancelled");
endmodule

// ==== logic/prf_pkg.sv ====
// Purpose: Types shared by the panel restart and filter block
// Assumes: Nothing beyond the types themselves
// Notes: Ack states follow a Gray path
package prf_pkg;
    typedef enum logic [2:0] {
        PRF_M_AUTO = 3'h0,
        PRF_M_COOL = 3'h1,
        PRF_M_HEAT = 3'h2,
        PRF_M_DRY = 3'h3,
        PRF_M_FAN = 3'h4
    } prf_mode_t;
    typedef enum logic [1:0] {
        PRF_SYS_HP = 2'h0,
        PRF_SYS_COOL = 2'h1,
        PRF_SYS_HEAT = 2'h2
    } prf_sys_t;
    typedef enum logic [2:0] {
        PRF_CMD_NONE = 3'h0,
        PRF_CMD_ON = 3'h1,
        PRF_CMD_OFF = 3'h2,
        PRF_CMD_ONE_TOUCH = 3'h3,
        PRF_CMD_MODE = 3'h4
    } prf_cmd_t;
    typedef enum logic [1:0] {
        PRF_ACK_IDLE = 2'b00,
        PRF_ACK_WAIT = 2'b01,
        PRF_ACK_BEEP = 2'b11,
        PRF_ACK_FLASH = 2'b10
    } prf_ack_t;
endpackage

// ==== logic/prf_regs.svh ====
// Purpose: Offsets, fields, reset values and timing for the panel block
// Assumes: 50 MHz pclk, one 100 ms tick drives all slow timing
// Notes: Times kept in their own units, tick counts derived from them
`ifndef PRF_REGS_SVH
`define PRF_REGS_SVH
`define PRF_CFG 8'h00
`define PRF_STATUS 8'h04
`define PRF_HOURS 8'h08
`define PRF_IRQ_STAT 8'h0c
`define PRF_IRQ_MASK 8'h10
`define PRF_LOUVER 8'h14
`define PRF_ST_RUN 0
`define PRF_ST_COMFORT 1
`define PRF_ST_RESTART 2
`define PRF_ST_FILTER 3
`define PRF_ST_MODE 4
`define PRF_EV_FILTER 0
`define PRF_EV_TOGGLE 1
`define PRF_EV_RESUME 2
`define PRF_EV_COMFORT 3
`define PRF_CFG_RST 2'h0
`define PRF_MASK_RST 4'h0
`define PRF_LOUVER_RST 16'h2222
`define PRF_CLK_HZ 50000000
`define PRF_TICK_MS 100
`define PRF_CYC_PER_TICK (`PRF_CLK_HZ / 1000 * `PRF_TICK_MS)
`define PRF_HOLD_MIN_MS 3000
`define PRF_HOLD_MAX_MS 10000
`define PRF_ACK_WAIT_MS 3000
`define PRF_FLASH_MS 5000
`define PRF_RESUME_MIN 3
`define PRF_FILTER_HRS 1000
`define PRF_BEEPS 3
`define PRF_COMFORT_C 5'd24
`define PRF_HOLD_MIN_T (`PRF_HOLD_MIN_MS / `PRF_TICK_MS)
`define PRF_HOLD_MAX_T (`PRF_HOLD_MAX_MS / `PRF_TICK_MS)
`define PRF_ACK_WAIT_T (`PRF_ACK_WAIT_MS / `PRF_TICK_MS)
`define PRF_FLASH_T (`PRF_FLASH_MS / `PRF_TICK_MS)
`define PRF_RESUME_T (`PRF_RESUME_MIN * 60000 / `PRF_TICK_MS)
`define PRF_FILTER_T (`PRF_FILTER_HRS * 3600 * (1000 / `PRF_TICK_MS))
`endif

// ==== verification/prf_user.sv ====
// Purpose: Panel button and remote controller acting on the panel block
// Assumes: Tick of cyc_per_tick pclk cycles
// Notes: Only well-formed commands and holds are produced
`timescale 1ns/1ps
module prf_user #(
    parameter int cyc_per_tick = 4
) (
    input wire logic pclk,
    output logic btn_n,
    output logic cmd_valid,
    output logic [2:0] cmd_code,
    output logic [2:0] cmd_mode,
    output logic [4:0] cmd_temp
);
    initial begin
        btn_n = 1'b1;
        cmd_valid = 1'b0;
        cmd_code = 3'h0;
        cmd_mode = 3'h0;
        cmd_temp = 5'h00;
    end
    task press(input int ticks);
        @(posedge pclk) btn_n <= 1'b0;
        repeat (ticks * cyc_per_tick) @(posedge pclk);
        btn_n <= 1'b1;
    endtask
    task send(input logic [2:0] c, input logic [2:0] m, input logic [4:0] t);
        @(posedge pclk);
        cmd_valid <= 1'b1;
        cmd_code <= c;
        cmd_mode <= m;
        cmd_temp <= t;
        @(posedge pclk) cmd_valid <= 1'b0;
    endtask
endmodule

// ==== verification/test_panel_restart_filter_control.sv ====
// Purpose: Self-checking bench for the panel restart and filter block
// Assumes: Short tick, filter and resume counts set by parameters
// Notes: Power return is modelled by a second and a third reset
`timescale 1ns/1ps
`include "prf_regs.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module test_panel_restart_filter_control;
    import prf_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, err, btn_n, cmd_valid, nvm_wr, run, comfort, restart_en;
    logic nvm_en, nvm_run, fan_auto, white_led, filter_led, beep, irq, pb, pw;
    logic [2:0] cmd_code, cmd_mode, op_mode, nvm_mode;
    logic [4:0] cmd_temp, target_temp, nvm_temp;
    logic [5:0] room_temp;
    logic [3:0] louver;
    int n_errors = 0, cmp_count = 0, nb, nf, nw;
    always #10 pclk = ~pclk;
    prf_user #(.cyc_per_tick(4)) user (.pclk(pclk), .btn_n(btn_n), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_mode(cmd_mode), .cmd_temp(cmd_temp));
    prf_panel #(.CYC_PER_TICK(4), .FILTER_TICKS(20), .RESUME_TICKS(5)) uut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .btn_n(btn_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_mode(cmd_mode),
        .cmd_temp(cmd_temp), .room_temp(room_temp), .nvm_restart_en(nvm_en),
        .nvm_run(nvm_run), .nvm_mode(nvm_mode), .nvm_temp(nvm_temp), .nvm_wr(nvm_wr),
        .run(run), .comfort(comfort), .restart_en(restart_en), .op_mode(op_mode),
        .target_temp(target_temp), .fan_auto(fan_auto), .louver(louver),
        .white_led(white_led), .filter_led(filter_led), .beep(beep), .irq(irq));
    task stop_test;
        if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task wt(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task power_up;
        @(posedge pclk) presetn <= 0;
        repeat (16) @(posedge pclk);
        presetn <= 1;
        wt(2);
    endtask
    task t_reset;
        nvm_en <= 1'b0;
        nvm_run <= 1'b1;
        nvm_mode <= 3'h2;
        nvm_temp <= 5'd26;
        room_temp <= 6'd23;
        paddr <= 8'h00;
        pwdata <= 32'h0;
        power_up();
        `CHK("restart_en", 1'b0, restart_en)
        wt(40);
        `CHK("run", 1'b0, run)
        apb(0, `PRF_CFG, 0);
        `CHK("cfg", 32'h0, rd)
        apb(0, `PRF_LOUVER, 0);
        `CHK("louver reg", 32'h2222, rd)
        apb(0, 8'h18, 0);
        `CHK("unmapped", 1'b1, err)
    endtask
    task t_filter;
        user.press(10);
        wt(8);
        `CHK("run", 1'b1, run)
        `CHK("temp", 5'd24, target_temp)
        wt(100);
        `CHK("filter", 1'b1, filter_led)
        `CHK("irq masked", 1'b0, irq)
        apb(1, `PRF_IRQ_MASK, 32'h1);
        wt(2);
        `CHK("irq", 1'b1, irq)
        apb(1, `PRF_IRQ_STAT, 32'h1);
        wt(2);
        `CHK("irq clr", 1'b0, irq)
        user.press(10);
        wt(8);
        `CHK("filter", 1'b0, filter_led)
        `CHK("run", 1'b1, run)
        apb(0, `PRF_HOURS, 0);
        `CHK("hours", 1'b1, rd < 20)
    endtask
    // Beeps and led toggles counted over the whole confirmation
    task hold_ack(input logic er, input logic ee);
        user.press(50);
        wt(8);
        `CHK("run", er, run)
        `CHK("restart_en", ee, restart_en)
        nb = 0;
        nf = 0;
        pb = beep;
        pw = white_led;
        for (int i = 0; i < 400; i++) begin
            @(posedge pclk);
            if (beep === 1'b1 && pb !== 1'b1) nb++;
            if (white_led !== pw) nf++;
            pb = beep;
            pw = white_led;
        end
        `CHK("beeps", 3, nb)
        `CHK("flash", 1'b1, nf > 8)
    endtask
    task t_hold;
        hold_ack(1'b0, 1'b1);
        hold_ack(1'b1, 1'b0);
        user.press(120);
        wt(8);
        `CHK("long hold", 1'b0, restart_en)
    endtask
    task t_touch;
        user.send(PRF_CMD_OFF, 0, 0);
        apb(1, `PRF_LOUVER, 32'h4321);
        room_temp <= 6'd30;
        nw = 0;
        user.send(PRF_CMD_ONE_TOUCH, 0, 0);
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            nw += (nvm_wr === 1'b1);
        end
        @(negedge pclk);
        `CHK("run", 1'b1, run)
        `CHK("comfort", 1'b1, comfort)
        `CHK("mode", PRF_M_COOL, op_mode)
        `CHK("temp", 5'd24, target_temp)
        `CHK("fan", 1'b1, fan_auto)
        `CHK("louver", 4'h1, louver)
        `CHK("nvm_wr", 1'b1, nw > 0)
        user.send(PRF_CMD_MODE, PRF_M_HEAT, 5'd20);
        wt(4);
        `CHK("comfort", 1'b0, comfort)
        `CHK("mode", PRF_M_HEAT, op_mode)
        `CHK("temp", 5'd20, target_temp)
        apb(1, `PRF_CFG, 32'h2);
        apb(0, `PRF_CFG, 0);
        `CHK("cfg", 32'h2, rd)
        user.send(PRF_CMD_ONE_TOUCH, 0, 0);
        wt(4);
        `CHK("heat only", PRF_M_FAN, op_mode)
    endtask
    task t_resume;
        nvm_en <= 1;
        nvm_mode <= 3'h1;
        nvm_temp <= 5'd19;
        power_up();
        `CHK("run early", 1'b0, run)
        wt(40);
        `CHK("run", 1'b1, run)
        `CHK("mode", PRF_M_COOL, op_mode)
        `CHK("temp", 5'd19, target_temp)
        nvm_run <= 1'b0;
        power_up();
        wt(40);
        `CHK("stopped", 1'b0, run)
    endtask
    initial begin
        t_reset();
        t_filter();
        t_hold();
        t_touch();
        t_resume();
        stop_test();
    end
    initial begin
        #1ms;
        n_errors++;
        stop_test();
    end
endmodule
